// ==== rtl/basic_status_consts.vh ====
// Constants for the basic link status register bank and its helpers
`ifndef BASIC_STATUS_CONSTS_VH
`define BASIC_STATUS_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------------
`define LINK_STATUS_OFS 8'h00
`define CONTROL_OFS 8'h04
`define EVENT_STATUS_OFS 8'h08
`define EVENT_MASK_OFS 8'h0c
`define MGMT_STATE_OFS 8'h10

// ----------------------------------------------------------------------
// Basic link status field positions
// ----------------------------------------------------------------------
`define TX100_FULL_BIT 14
`define TX100_HALF_BIT 13
`define T10_FULL_BIT 12
`define T10_HALF_BIT 11
`define RESV_HI_BIT 10
`define RESV_LO_BIT 7
`define PREAMBLE_SKIP_BIT 6
`define AN_DONE_BIT 5
`define REMOTE_FAULT_BIT 4
`define AN_ABLE_BIT 3
`define LINK_UP_BIT 2

// ----------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------
`define CTRL_AN_ENABLE_BIT 0
`define CTRL_AN_RESTART_BIT 1
`define CTRL_AN_ENABLE_RST 1'h1

// ----------------------------------------------------------------------
// Event status and mask fields
// ----------------------------------------------------------------------
`define EV_REMOTE_FAULT_BIT 0
`define EV_AN_DONE_BIT 1
`define EV_LINK_CHANGE_BIT 2
`define EV_FRAME_REFUSED_BIT 3
`define EV_WIDTH 4
`define EV_MASK_RST 4'h0

// ----------------------------------------------------------------------
// Management state register fields
// ----------------------------------------------------------------------
`define MS_PREAMBLE_NEEDED_BIT 0
`define MS_AN_STATE_LO_BIT 4

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define PREAMBLE_BITS 32

`endif

// ==== rtl/basic_status_regs.v ====
// Basic link status register bank with Wishbone slave and interrupt
// Notes on behaviour
// - Bit 13 always reads 1: 100 Mbit twisted-pair half duplex supported.
// - Bit 12 always reads 1: 10 Mbit twisted-pair full duplex supported.
// - Bit 11 always reads 1: 10 Mbit twisted-pair half duplex supported.
// - Bits 10 to 7 read zero; writers should put zero there.
// - Bit 6 reads 1: frames without preamble are accepted.
// - Full 32-bit preamble needed after reset or a bad frame; otherwise optional.
// - Bit 5 is 1 only after negotiation finished; 0 when running, disabled, reset.
// - Bit 4 latches on far-end or partner remote fault; read or reset clears.
// - Bit 3 always reads 1: auto-negotiation supported.
// - Link bit is 1 while a valid 10 or 100 Mbit link exists.
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "basic_status_consts.vh"
module basic_status_regs #(
  parameter ADDR_WIDTH = 8,
  parameter PREAMBLE_LEN = `PREAMBLE_BITS,
  parameter TX100_FULL_CAP = 1'b0
) (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADDR_WIDTH-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire link_up_10,
  input wire link_up_100,
  input wire an_finished,
  input wire far_end_fault,
  input wire partner_remote_fault,
  input wire mgmt_bit_valid,
  input wire mgmt_bit,
  input wire mgmt_frame_start,
  input wire mgmt_frame_invalid,
  output reg an_run_reg,
  output reg frame_accept_reg,
  output reg frame_refuse_reg,
  output reg irq_reg
);

  // --------------------------------------------------------------------
  // Negotiation states
  // --------------------------------------------------------------------
  localparam AN_OFF = 2'h0;
  localparam AN_RUNNING = 2'h1;
  localparam AN_DONE = 2'h2;

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  reg [1:0] an_state_reg;
  reg [1:0] an_state_next;
  reg an_enable_reg;
  reg an_restart_reg;
  reg link_reg;
  reg link_prev_reg;
  reg [`EV_WIDTH-1:0] ev_mask_reg;
  reg [31:0] read_value;
  wire access;
  wire take;
  wire rd_take;
  wire wr_take;
  wire [ADDR_WIDTH-1:0] word_adr;
  wire remote_fault_q;
  wire [`EV_WIDTH-1:0] ev_flags;
  wire [`EV_WIDTH-1:0] ev_set;
  wire [`EV_WIDTH-1:0] ev_clear;
  wire preamble_needed;
  wire gate_accept;
  wire gate_refuse;
  wire fault_seen;
  wire link_now;
  wire an_done_pulse;
  wire [15:0] status_word;
  wire stat_rd;
  wire ev_rd;
  wire ctrl_wr;
  wire mask_wr;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------

  // Byte address compared on whole words; low two bits ignored
  function hit;
    input [ADDR_WIDTH-1:0] adr;
    input [7:0] ofs;
    begin
      hit = (adr == ofs[ADDR_WIDTH-1:0]);
    end
  endfunction

  // A request is taken once; ack drops the cycle after it is given
  assign access = wb_cyc_i & wb_stb_i;
  assign take = access & ~wb_ack_o;
  assign rd_take = take & ~wb_we_i;
  assign wr_take = take & wb_we_i;
  assign word_adr = {wb_adr_i[ADDR_WIDTH-1:2], 2'b00};

  // --------------------------------------------------------------------
  // Access strobes
  // --------------------------------------------------------------------

  // Read strobes fire on the taking edge, as the answer data is captured
  assign stat_rd = rd_take & hit(word_adr, `LINK_STATUS_OFS);
  assign ev_rd = rd_take & hit(word_adr, `EVENT_STATUS_OFS);

  // Write strobes honour only the low byte lane, where all writable bits sit
  assign ctrl_wr = wr_take & wb_sel_i[0] & hit(word_adr, `CONTROL_OFS);
  assign mask_wr = wr_take & wb_sel_i[0] & hit(word_adr, `EVENT_MASK_OFS);

  // --------------------------------------------------------------------
  // Status word assembly
  // --------------------------------------------------------------------

  // Capability bits are constants; reserved and unlisted bits read zero
  assign status_word = {
    1'b0,
    TX100_FULL_CAP[0],
    1'b1,
    1'b1,
    1'b1,
    4'h0,
    1'b1,
    (an_state_reg == AN_DONE),
    remote_fault_q,
    1'b1,
    link_reg,
    2'b00
  };

  // --------------------------------------------------------------------
  // Remote fault latch
  // --------------------------------------------------------------------

  // Either fault source latches; a read of the status word clears it
  assign fault_seen = far_end_fault | partner_remote_fault;

  // Set wins, so a fault arriving in the read cycle is not lost
  event_latch #(
    .WIDTH(1)
  ) fault_latch (
    .clk(clk),
    .rst(rst),
    .set(fault_seen),
    .clear(stat_rd),
    .flags_reg(remote_fault_q)
  );

  // --------------------------------------------------------------------
  // Link status
  // --------------------------------------------------------------------

  // Either speed counts as a valid link
  assign link_now = link_up_10 | link_up_100;

  // Registered so the read value and the change event agree
  always @(posedge clk) begin
    if (rst) begin
      link_reg <= 1'b0;
      link_prev_reg <= 1'b0;
    end else begin
      link_reg <= link_now;
      link_prev_reg <= link_reg;
    end
  end

  // --------------------------------------------------------------------
  // Auto-negotiation progress
  // --------------------------------------------------------------------

  // Done only after the engine reports the end; loss of link restarts
  always @* begin
    an_state_next = an_state_reg;
    case (an_state_reg)
      AN_OFF: begin
        if (an_enable_reg) begin
          an_state_next = AN_RUNNING;
        end
      end
      AN_RUNNING: begin
        if (!an_enable_reg) begin
          an_state_next = AN_OFF;
        end else if (an_finished && !an_restart_reg) begin
          an_state_next = AN_DONE;
        end
      end
      AN_DONE: begin
        if (!an_enable_reg) begin
          an_state_next = AN_OFF;
        end else if (an_restart_reg || (link_prev_reg && !link_reg)) begin
          an_state_next = AN_RUNNING;
        end
      end
      default: begin
        an_state_next = AN_OFF;
      end
    endcase
  end

  // State register; reset leaves the done bit low
  always @(posedge clk) begin
    if (rst) begin
      an_state_reg <= AN_OFF;
      an_run_reg <= 1'b0;
    end else begin
      an_state_reg <= an_state_next;
      an_run_reg <= (an_state_next == AN_RUNNING);
    end
  end

  // One-cycle pulse on entry to done, for the event flag
  assign an_done_pulse = (an_state_reg != AN_DONE) && (an_state_next == AN_DONE);

  // --------------------------------------------------------------------
  // Management preamble handling
  // --------------------------------------------------------------------

  // Decides per frame whether the preamble seen was sufficient
  mgmt_preamble_gate #(
    .PREAMBLE_LEN(PREAMBLE_LEN)
  ) preamble_gate (
    .clk(clk),
    .rst(rst),
    .bit_valid(mgmt_bit_valid),
    .bit_value(mgmt_bit),
    .frame_start(mgmt_frame_start),
    .frame_invalid(mgmt_frame_invalid),
    .frame_accept_reg(gate_accept),
    .frame_refuse_reg(gate_refuse),
    .preamble_needed_reg(preamble_needed)
  );

  // Re-registered so the top outputs come straight from flip-flops
  always @(posedge clk) begin
    if (rst) begin
      frame_accept_reg <= 1'b0;
      frame_refuse_reg <= 1'b0;
    end else begin
      frame_accept_reg <= gate_accept;
      frame_refuse_reg <= gate_refuse;
    end
  end

  // --------------------------------------------------------------------
  // Event flags and interrupt
  // --------------------------------------------------------------------

  // Each event sets a sticky flag
  assign ev_set[`EV_REMOTE_FAULT_BIT] = fault_seen;
  assign ev_set[`EV_AN_DONE_BIT] = an_done_pulse;
  assign ev_set[`EV_LINK_CHANGE_BIT] = link_reg ^ link_prev_reg;
  assign ev_set[`EV_FRAME_REFUSED_BIT] = gate_refuse;

  // Reading the event register clears every flag it returned
  assign ev_clear = {`EV_WIDTH{ev_rd}};

  // Same set-wins latch, one bit per event
  event_latch #(
    .WIDTH(`EV_WIDTH)
  ) ev_latch (
    .clk(clk),
    .rst(rst),
    .set(ev_set),
    .clear(ev_clear),
    .flags_reg(ev_flags)
  );

  // Level interrupt while any unmasked flag is set
  always @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(ev_flags & ev_mask_reg);
    end
  end

  // --------------------------------------------------------------------
  // Software writes
  // --------------------------------------------------------------------

  // Only low byte lane carries writable bits; the status word is fixed
  always @(posedge clk) begin
    if (rst) begin
      an_enable_reg <= `CTRL_AN_ENABLE_RST;
      an_restart_reg <= 1'b0;
      ev_mask_reg <= `EV_MASK_RST;
    end else begin
      an_restart_reg <= 1'b0; // Self-clearing request
      if (ctrl_wr) begin
        an_enable_reg <= wb_dat_i[`CTRL_AN_ENABLE_BIT];
        an_restart_reg <= wb_dat_i[`CTRL_AN_RESTART_BIT];
      end
      if (mask_wr) begin
        ev_mask_reg <= wb_dat_i[`EV_WIDTH-1:0];
      end
      // Status word writes have no strobe and fall through with no effect
    end
  end

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------

  // Unmapped addresses read zero and still answer
  always @* begin
    read_value = 32'h0000_0000;
    if (hit(word_adr, `LINK_STATUS_OFS)) begin
      read_value[15:0] = status_word;
    end else if (hit(word_adr, `CONTROL_OFS)) begin
      read_value[`CTRL_AN_ENABLE_BIT] = an_enable_reg;
    end else if (hit(word_adr, `EVENT_STATUS_OFS)) begin
      read_value[`EV_WIDTH-1:0] = ev_flags;
    end else if (hit(word_adr, `EVENT_MASK_OFS)) begin
      read_value[`EV_WIDTH-1:0] = ev_mask_reg;
    end else if (hit(word_adr, `MGMT_STATE_OFS)) begin
      read_value[`MS_PREAMBLE_NEEDED_BIT] = preamble_needed;
      read_value[`MS_AN_STATE_LO_BIT+1:`MS_AN_STATE_LO_BIT] = an_state_reg;
    end
  end

  // --------------------------------------------------------------------
  // Bus answer
  // --------------------------------------------------------------------

  // One wait state: ack one edge after the request is seen
  always @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= take;
      if (rd_take) begin
        wb_dat_o <= read_value;
      end
    end
  end

endmodule // basic_status_regs

// ==== rtl/event_latch.v ====
// Sticky flag bank: hardware sets, a clear pulse resets, set wins
`timescale 1ns/1ps
module event_latch #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] set,
  input wire [WIDTH-1:0] clear,
  output reg [WIDTH-1:0] flags_reg
);

  wire [WIDTH-1:0] flags_next;

  // Set overrides clear so an event in the clearing cycle survives
  assign flags_next = (flags_reg & ~clear) | set;

  // Flag storage
  always @(posedge clk) begin
    if (rst) begin
      flags_reg <= {WIDTH{1'b0}};
    end else begin
      flags_reg <= flags_next;
    end
  end

endmodule // event_latch

// ==== rtl/mgmt_preamble_gate.v ====
// Management frame preamble tracker: decides whether a frame may run
`timescale 1ns/1ps
`include "basic_status_consts.vh"
module mgmt_preamble_gate #(
  parameter PREAMBLE_LEN = `PREAMBLE_BITS
) (
  input wire clk,
  input wire rst,
  input wire bit_valid,
  input wire bit_value,
  input wire frame_start,
  input wire frame_invalid,
  output reg frame_accept_reg,
  output reg frame_refuse_reg,
  output reg preamble_needed_reg
);

  reg [5:0] ones_reg;
  reg [5:0] ones_next;
  wire long_enough;

  assign long_enough = (ones_reg >= PREAMBLE_LEN[5:0]);

  // Run of consecutive one bits, saturating at the preamble length
  always @* begin
    ones_next = ones_reg;
    if (frame_start) begin
      ones_next = 6'h00;
    end else if (bit_valid) begin
      if (!bit_value) begin
        ones_next = 6'h00;
      end else if (!long_enough) begin
        ones_next = ones_reg + 6'h01;
      end
    end
  end

  // Full preamble needed after reset and after a bad frame
  always @(posedge clk) begin
    if (rst) begin
      ones_reg <= 6'h00;
      preamble_needed_reg <= 1'b1;
      frame_accept_reg <= 1'b0;
      frame_refuse_reg <= 1'b0;
    end else begin
      ones_reg <= ones_next;
      frame_accept_reg <= frame_start & (~preamble_needed_reg | long_enough);
      frame_refuse_reg <= frame_start & preamble_needed_reg & ~long_enough;
      if (frame_invalid) begin
        preamble_needed_reg <= 1'b1;
      end else if (frame_start && long_enough) begin
        preamble_needed_reg <= 1'b0;
      end
    end
  end

endmodule // mgmt_preamble_gate

// ==== testbench/mgmt_master_model.sv ====
// Behavioural management controller driving the serial frame side
`timescale 1ns/1ps
module mgmt_master_model (
  input wire clk,
  input wire frame_accept_reg,
  input wire frame_refuse_reg,
  output reg mgmt_bit_valid,
  output reg mgmt_bit,
  output reg mgmt_frame_start,
  output reg mgmt_frame_invalid
);
  // Idle values at time zero
  initial begin
    mgmt_bit_valid = 1'b0;
    mgmt_bit = 1'b0;
    mgmt_frame_start = 1'b0;
    mgmt_frame_invalid = 1'b0;
  end
  // n preamble ones, then start; verdict pulses gathered over a short window
  task send(input integer n, output [1:0] res);
    integer i;
    begin
      res = 2'b00;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk);
        mgmt_bit_valid <= 1'b1;
        mgmt_bit <= 1'b1;
      end
      @(posedge clk);
      mgmt_bit_valid <= 1'b0;
      mgmt_bit <= 1'b0; // Released line shows the inverse, never a stale one
      mgmt_frame_start <= 1'b1;
      @(posedge clk);
      mgmt_frame_start <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge clk);
        res = res | {frame_accept_reg, frame_refuse_reg};
      end
    end
  endtask
  // Bad opcode or turnaround: the next frame needs a full preamble again
  task spoil;
    begin
      @(posedge clk);
      mgmt_frame_invalid <= 1'b1;
      @(posedge clk);
      mgmt_frame_invalid <= 1'b0;
    end
  endtask
endmodule // mgmt_master_model

// ==== testbench/status_props_properties.sv ====
// Concurrent checks on the status register bank ports
`timescale 1ns/1ps
`include "basic_status_consts.vh"
module status_props #(
  parameter ADDR_WIDTH = 8
) (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADDR_WIDTH-1:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire link_up_10,
  input wire link_up_100,
  input wire an_run_reg,
  input wire mgmt_frame_start,
  input wire frame_accept_reg,
  input wire frame_refuse_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reg rd_stat_reg;
  wire lk = link_up_10 | link_up_100;
  // -----------------------------------------------------------------
  // Status read tracker
  // -----------------------------------------------------------------
  // Marks the answer cycle of a status read, so data checks hit only it
  always @(posedge clk) begin
    rd_stat_reg <= !rst && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h00;
  end
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  duplex_caps_a: assert property (wb_ack_o && rd_stat_reg |-> wb_dat_o[13:11] == 3'h7)
    else $error("duplex bits wrong");
  resv_zero_a: assert property (wb_ack_o && rd_stat_reg |-> wb_dat_o[10:7] == 4'h0)
    else $error("reserved bits set");
  mgmt_caps_a: assert property (wb_ack_o && rd_stat_reg |-> wb_dat_o[6] && wb_dat_o[3])
    else $error("capability bit clear");
  link_bit_a: assert property (wb_ack_o && rd_stat_reg && $past(lk, 2) == $past(lk, 3)
    && $past(lk) == $past(lk, 2) |-> wb_dat_o[2] == $past(lk)) else $error("link bit wrong");
  an_running_a: assert property (wb_ack_o && rd_stat_reg && $past(an_run_reg)
    && $past(an_run_reg, 2) |-> !wb_dat_o[5]) else $error("done while running");
  frame_gate_a: assert property (mgmt_frame_start |-> ##2 (frame_accept_reg != frame_refuse_reg))
    else $error("no frame verdict");
  frame_cause_a: assert property (frame_accept_reg || frame_refuse_reg |-> $past(mgmt_frame_start, 2))
    else $error("stray frame verdict");
endmodule // status_props

bind basic_status_regs status_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.clk(clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_up_10(link_up_10), .link_up_100(link_up_100),
  .an_run_reg(an_run_reg), .mgmt_frame_start(mgmt_frame_start),
  .frame_accept_reg(frame_accept_reg), .frame_refuse_reg(frame_refuse_reg));

// ==== testbench/test_basic_status_regs.sv ====
// Self-checking bench for the basic link status register bank
`timescale 1ns/1ps
module test_basic_status_regs;
  localparam PRE_LEN = 8;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [31:0] wb_dat_i = 32'h0;
  reg [1:0] lk = 2'h0;
  reg [2:0] ev = 3'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire an_run_reg;
  wire frame_accept_reg;
  wire frame_refuse_reg;
  wire irq_reg;
  wire bv;
  wire bt;
  wire fs;
  wire fi;
  integer err_count = 0;
  integer n_checks = 0;
  integer k;
  reg [31:0] d;
  reg [1:0] res;
  // Short preamble keeps frame runs brief
  basic_status_regs #(.PREAMBLE_LEN(PRE_LEN)) DUT (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_up_10(lk[0]),
    .link_up_100(lk[1]), .an_finished(ev[0]), .far_end_fault(ev[1]),
    .partner_remote_fault(ev[2]), .mgmt_bit_valid(bv), .mgmt_bit(bt), .mgmt_frame_start(fs),
    .mgmt_frame_invalid(fi), .an_run_reg(an_run_reg), .frame_accept_reg(frame_accept_reg),
    .frame_refuse_reg(frame_refuse_reg), .irq_reg(irq_reg));
  mgmt_master_model mgmt (.clk(clk), .frame_accept_reg(frame_accept_reg),
    .frame_refuse_reg(frame_refuse_reg), .mgmt_bit_valid(bv), .mgmt_bit(bt),
    .mgmt_frame_start(fs), .mgmt_frame_invalid(fi));
  // -----------------------------------------------------------------
  // Clock and helpers
  // -----------------------------------------------------------------
  initial begin
    forever #12.5 clk = ~clk;
  end
  task close_out;
    begin
      if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // Classic single cycle; ack and data are taken at the same edge
  task xfer(input w, input [7:0] adr, input [31:0] wd);
    integer i;
    begin
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      for (i = 0; i < 16 && wb_ack_o !== 1'b1; i = i + 1) @(posedge clk);
      if (i == 16) begin
        err_count = err_count + 1;
        close_out;
      end
      d = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
    end
  endtask
  task pulse(input [2:0] m);
    begin
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 3'h0;
      repeat (3) @(posedge clk);
    end
  endtask
  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b0, 8'h00, 32'h0);
    check(d, 32'h0000_3848);
    xfer(1'b1, 8'h00, 32'h0000_f87f);
    xfer(1'b0, 8'h00, 32'h0);
    check(d, 32'h0000_3848);
    xfer(1'b0, 8'h20, 32'h0);
    check(d, 32'h0);
    // Negotiation: running, done, then disabled
    for (k = 0; k < 20 && an_run_reg !== 1'b1; k = k + 1) @(posedge clk);
    check(an_run_reg, 1'b1);
    xfer(1'b0, 8'h00, 32'h0);
    check(d & 32'h20, 32'h0);
    pulse(3'b001);
    xfer(1'b0, 8'h00, 32'h0);
    check(d & 32'h20, 32'h20);
    xfer(1'b1, 8'h04, 32'h0);
    xfer(1'b0, 8'h00, 32'h0);
    check(d & 32'h20, 32'h0);
    xfer(1'b1, 8'h04, 32'h1);
    // Link at each speed and none
    for (k = 0; k < 4; k = k + 1) begin
      lk <= k[1:0];
      repeat (3) @(posedge clk);
      xfer(1'b0, 8'h00, 32'h0);
      check(d & 32'h4, (k != 0) ? 32'h4 : 32'h0);
    end
    // Both fault sources latch, a read clears
    for (k = 1; k < 3; k = k + 1) begin
      pulse(3'b001 << k);
      xfer(1'b0, 8'h00, 32'h0);
      check(d & 32'h10, 32'h10);
      xfer(1'b0, 8'h00, 32'h0);
      check(d & 32'h10, 32'h0);
    end
    // Interrupt raised, cleared by read, then masked
    xfer(1'b0, 8'h08, 32'h0);
    xfer(1'b1, 8'h0c, 32'h1);
    pulse(3'b010);
    check(irq_reg, 1'b1);
    xfer(1'b0, 8'h08, 32'h0);
    check(d & 32'h1, 32'h1);
    repeat (2) @(posedge clk);
    check(irq_reg, 1'b0);
    xfer(1'b1, 8'h0c, 32'h0);
    pulse(3'b100);
    check(irq_reg, 1'b0);
    // Preamble needed after reset and after a bad frame only
    mgmt.send(0, res);
    check(res, 2'b01);
    mgmt.send(PRE_LEN, res);
    check(res, 2'b10);
    mgmt.send(0, res);
    check(res, 2'b10);
    mgmt.spoil;
    mgmt.send(PRE_LEN - 1, res);
    check(res, 2'b01);
    mgmt.send(PRE_LEN, res);
    check(res, 2'b10);
    close_out;
  end
endmodule // test_basic_status_regs
